// [logic/iclg_pkg.sv]
// Constants and types shared by the interrupt control logic
package iclg_pkg;
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam int NUM_SRC = 3;
    localparam int PORT_W = 4;
    localparam int EV_W = 3;
    localparam int PC_W = 13;
    // Register offsets
    localparam logic [1:0] OFF_CTRL = 2'h0;
    localparam logic [1:0] OFF_EVSTAT = 2'h1;
    localparam logic [1:0] OFF_EVMASK = 2'h2;
    localparam logic [1:0] OFF_STATE = 2'h3;
    // Control register fields: flags in [2:0], enables in [5:3], same source order
    localparam int GIE_BIT = 7;
    localparam int EN_LSB = 3;
    localparam int FLAG_LSB = 0;
    localparam int SRC_PORT = 0;
    localparam int SRC_EXT = 1;
    localparam int SRC_TMR = 2;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] CTRL_MASK = 8'hbf;
    // Event status bits
    localparam int EV_TAKE = 0;
    localparam int EV_RET = 1;
    localparam int EV_BLOCK = 2;
    localparam logic [2:0] EV_RESET = 3'h0;
    // Core timing
    localparam logic [1:0] Q_LAST = 2'h3;
    localparam logic [1:0] Q_FIRST = 2'h0;
    localparam logic [12:0] VECTOR_ADDR = 13'h0004;
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_DUMMY = 2'b01,
        ST_VECTOR = 2'b10
    } iclg_state_t;
endpackage

// [logic/iclg_sync2.sv]
// Two-stage synchroniser, parameterised width
`timescale 1ns/1ps
`default_nettype none
module iclg_sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= '0;
            q <= '0;
        end else if (ce) begin
            meta <= d;
            q <= meta;
        end
    end
endmodule
`default_nettype wire

// [logic/iclg_interrupt_control.sv]
// Interrupt control logic: source flags, enables, core redirection to the vector
`timescale 1ns/1ps
`default_nettype none
module iclg_interrupt_control (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic [1:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdData,
    input wire logic externalIntPin,
    input wire logic [3:0] portBUpperPins,
    input wire logic timerZeroOverflow,
    input wire logic returnFromService,
    output logic intPending,
    output logic forceNop,
    output logic pushReturn,
    output logic vectorLoad,
    output logic [12:0] vectorAddr,
    output logic irqOut
);
    // ----------------------------------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------------------------------
    logic rstSync;
    logic extSync;
    logic [3:0] portSync;
    logic extPrev;
    logic [3:0] portPrev;
    logic primed;
    logic [1:0] primeShift;

    iclg_sync2 #(.W(1)) uRstSync (
        .clk(ref_clk),
        .rst_b(rst_b),
        .ce(1'b1),
        .d(1'b1),
        .q(rstSync)
    );

    iclg_sync2 #(.W(1)) uExtSync (
        .clk(ref_clk),
        .rst_b(rstSync),
        .ce(clkEn),
        .d(externalIntPin),
        .q(extSync)
    );

    iclg_sync2 #(.W(4)) uPortSync (
        .clk(ref_clk),
        .rst_b(rstSync),
        .ce(clkEn),
        .d(portBUpperPins),
        .q(portSync)
    );

    // Prime waits until the synchroniser and the previous sample both hold pin values,
    // since pins need not sit at zero when reset ends
    always_ff @(posedge ref_clk or negedge rstSync) begin
        if (!rstSync) begin
            extPrev <= 1'b0;
            portPrev <= '0;
            primeShift <= 2'h0;
            primed <= 1'b0;
        end else if (clkEn) begin
            extPrev <= extSync;
            portPrev <= portSync;
            primeShift <= {primeShift[0], 1'b1};
            primed <= primeShift[1];
        end
    end

    // ----------------------------------------------------------------
    // Source events and decode
    // ----------------------------------------------------------------
    logic [7:0] ctrlReg;
    logic [2:0] evStatus;
    logic [2:0] evMask;
    logic [1:0] qPhase;
    logic gieClrSeen;
    iclg_pkg::iclg_state_t state;

    wire extRise = primed && extSync && !extPrev;
    wire portChange = primed && (portSync != portPrev);
    wire [2:0] srcEvent = {timerZeroOverflow, extRise, portChange};
    // flags and enables in control register
    wire [2:0] flags = ctrlReg[iclg_pkg::FLAG_LSB +: iclg_pkg::NUM_SRC];
    wire [2:0] enables = ctrlReg[iclg_pkg::EN_LSB +: iclg_pkg::NUM_SRC];
    wire global_int_enable = ctrlReg[iclg_pkg::GIE_BIT];

    wire ctrlWr = regWr && (regAddr == iclg_pkg::OFF_CTRL);
    wire evStatWr = regWr && (regAddr == iclg_pkg::OFF_EVSTAT);
    wire evMaskWr = regWr && (regAddr == iclg_pkg::OFF_EVMASK);
    wire gieWriteClear = ctrlWr && !regWrData[iclg_pkg::GIE_BIT];
    wire gieDropped = gieWriteClear || gieClrSeen;

    // request needs flag, enable and global enable
    // global enable gates every source; per-source enables
    wire intReq = global_int_enable && (|(flags & enables));
    wire cycleEnd = (qPhase == iclg_pkg::Q_LAST);
    // acceptance only at instruction-cycle boundaries, never per instruction
    wire atBoundary = cycleEnd && (state == iclg_pkg::ST_RUN);
    // a due request is dropped when the global enable was just cleared
    wire take = atBoundary && intReq && !gieDropped;
    wire blocked = atBoundary && (|(flags & enables)) && gieDropped;

    // ----------------------------------------------------------------
    // Control register next value
    // ----------------------------------------------------------------
    logic [7:0] next_ctrl;

    always_comb begin
        next_ctrl = ctrlReg;
        if (ctrlWr) begin
            next_ctrl = regWrData & iclg_pkg::CTRL_MASK;
        end
        if (returnFromService) begin
            next_ctrl[iclg_pkg::GIE_BIT] = 1'b1;
        end
        if (take) begin
            next_ctrl[iclg_pkg::GIE_BIT] = 1'b0;
        end
        // flags set regardless of enables; set beats a software clear
        next_ctrl[iclg_pkg::FLAG_LSB +: iclg_pkg::NUM_SRC] =
            next_ctrl[iclg_pkg::FLAG_LSB +: iclg_pkg::NUM_SRC] | srcEvent;
    end

    // flags are only cleared by a control register write or by reset
    always_ff @(posedge ref_clk or negedge rstSync) begin
        if (!rstSync) begin
            ctrlReg <= iclg_pkg::CTRL_RESET;
        end else if (clkEn) begin
            ctrlReg <= next_ctrl;
        end
    end

    // ----------------------------------------------------------------
    // Instruction phase and entry sequence
    // ----------------------------------------------------------------
    iclg_pkg::iclg_state_t next_state;

    always_comb begin
        next_state = state;
        case (state)
            iclg_pkg::ST_RUN: begin
                if (take) begin
                    next_state = iclg_pkg::ST_DUMMY;
                end
            end
            iclg_pkg::ST_DUMMY: begin
                if (cycleEnd) begin
                    next_state = iclg_pkg::ST_VECTOR;
                end
            end
            iclg_pkg::ST_VECTOR: begin
                if (cycleEnd) begin
                    next_state = iclg_pkg::ST_RUN;
                end
            end
            default: begin
                next_state = iclg_pkg::ST_RUN;
            end
        endcase
    end

    // event, boundary, dummy cycle, then vector fetch: three or four cycles
    wire next_vectorLoad = (state == iclg_pkg::ST_DUMMY) && cycleEnd;

    always_ff @(posedge ref_clk or negedge rstSync) begin
        if (!rstSync) begin
            state <= iclg_pkg::ST_RUN;
            qPhase <= iclg_pkg::Q_FIRST;
            vectorLoad <= 1'b0;
            pushReturn <= 1'b0;
            vectorAddr <= iclg_pkg::VECTOR_ADDR;
        end else if (clkEn) begin
            state <= next_state;
            qPhase <= qPhase + 2'h1;
            // push return address and load the vector together
            vectorLoad <= next_vectorLoad;
            pushReturn <= next_vectorLoad;
            vectorAddr <= iclg_pkg::VECTOR_ADDR;
        end
    end

    // no-op follows any instruction cycle with a control write clearing the global enable
    // flags untouched, so dropped requests return once enabled
    always_ff @(posedge ref_clk or negedge rstSync) begin
        if (!rstSync) begin
            gieClrSeen <= 1'b0;
            forceNop <= 1'b0;
            intPending <= 1'b0;
        end else if (clkEn) begin
            if (cycleEnd) begin
                gieClrSeen <= 1'b0;
                forceNop <= gieDropped;
            end else if (gieWriteClear) begin
                gieClrSeen <= 1'b1;
            end
            intPending <= intReq;
        end
    end

    // ----------------------------------------------------------------
    // Event status, mask and interrupt line
    // ----------------------------------------------------------------
    wire [2:0] evSet = {blocked, returnFromService, take};
    wire [2:0] evClr = evStatWr ? regWrData[2:0] : 3'h0;
    // Set wins over a write-one-to-clear in the same cycle
    wire [2:0] next_evStatus = (evStatus & ~evClr) | evSet;

    always_ff @(posedge ref_clk or negedge rstSync) begin
        if (!rstSync) begin
            evStatus <= iclg_pkg::EV_RESET;
            evMask <= iclg_pkg::EV_RESET;
            irqOut <= 1'b0;
        end else if (clkEn) begin
            evStatus <= next_evStatus;
            if (evMaskWr) begin
                evMask <= regWrData[2:0];
            end
            irqOut <= |(evStatus & evMask);
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    wire [7:0] stateView = {4'h0, forceNop, intReq, state};
    wire [7:0] rdMux =
        (regAddr == iclg_pkg::OFF_CTRL) ? ctrlReg :
        (regAddr == iclg_pkg::OFF_EVSTAT) ? {5'h00, evStatus} :
        (regAddr == iclg_pkg::OFF_EVMASK) ? {5'h00, evMask} : stateView;

    // Data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rstSync) begin
        if (!rstSync) begin
            regRdData <= 8'h00;
        end else if (clkEn) begin
            regRdData <= regRd ? rdMux : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstSync);

    a_reset_gie_clear: assert property ($rose(rstSync) |-> !global_int_enable)
        else $error("global enable set after reset");
    a_take_gated: assert property (
        clkEn && state == iclg_pkg::ST_RUN && !(global_int_enable && (|(flags & enables)))
        |=> state == iclg_pkg::ST_RUN)
        else $error("interrupt taken without enabled pending flag");
    a_take_gie_off: assert property (
        clkEn && take |=> !global_int_enable && state == iclg_pkg::ST_DUMMY)
        else $error("acceptance did not clear global enable");
    a_vector_load: assert property (
        clkEn && state == iclg_pkg::ST_DUMMY && cycleEnd
        |=> vectorLoad && pushReturn && vectorAddr == iclg_pkg::VECTOR_ADDR)
        else $error("vector load missing after dummy cycle");
    a_load_pulse: assert property (clkEn && vectorLoad |=> !vectorLoad)
        else $error("vector load longer than one clock");
    a_return_gie: assert property (clkEn && returnFromService && !take |=> global_int_enable)
        else $error("return did not set global enable");
    a_flag_event: assert property (
        clkEn && timerZeroOverflow |=> ctrlReg[iclg_pkg::SRC_TMR])
        else $error("timer flag not set on overflow");
    a_flag_port: assert property (
        clkEn && portChange |=> flags[iclg_pkg::SRC_PORT])
        else $error("port flag not set on pin change");
    a_flag_ext: assert property (
        clkEn && extRise |=> flags[iclg_pkg::SRC_EXT])
        else $error("external flag not set on pin edge");
    a_flag_hold: assert property (
        clkEn && !ctrlWr |=> (flags & $past(flags)) == $past(flags))
        else $error("flag cleared without a register write");
    a_nop_next: assert property (clkEn && cycleEnd && gieDropped |=> forceNop)
        else $error("no-op not forced after global enable clear");
    a_clear_blocks: assert property (
        clkEn && gieWriteClear && state == iclg_pkg::ST_RUN |=> state == iclg_pkg::ST_RUN)
        else $error("interrupt taken after global enable clear");

    c_take: cover property (take);
    c_return: cover property (returnFromService && !global_int_enable);
    c_blocked: cover property (blocked);
    c_irq: cover property ($rose(irqOut));
endmodule
`default_nettype wire

// [testbench/iclg_core_model.sv]
// Core sequencer model facing the interrupt control logic
`timescale 1ns/1ps
`default_nettype none
module iclg_core_model (
    input wire logic ref_clk,
    input wire logic retReq,
    input wire logic vectorLoad,
    input wire logic pushReturn,
    input wire logic [12:0] vectorAddr,
    output logic returnFromService,
    output int entries,
    output int faults
);
    int entryCount = 0;
    int faultCount = 0;
    logic retQ = 1'b0;

    assign returnFromService = retQ;
    assign entries = entryCount;
    assign faults = faultCount;
    // Return only on request, one clock after retReq
    always @(posedge ref_clk) begin
        retQ <= retReq;
    end
    // Push and vector load together, vector fixed
    always @(posedge ref_clk) begin
        if (vectorLoad === 1'b1) begin
            entryCount <= entryCount + 1;
        end
        if (vectorLoad !== pushReturn || (vectorLoad && vectorAddr !== 13'h0004)) begin
            faultCount <= faultCount + 1;
        end
    end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the interrupt control logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk, ret, intPending, forceNop, pushReturn, vectorLoad, irqOut;
    logic rst_b = 1'b0, clkEn = 1'b1, regWr = 1'b0, regRd = 1'b0;
    logic extPin = 1'b0, tmrOv = 1'b0, retReq = 1'b0;
    logic [1:0] regAddr = 2'h0;
    logic [7:0] regWrData = 8'h00, regRdData, rdv;
    logic [3:0] portPins = 4'h0;
    logic [12:0] vectorAddr;
    int miscompares = 0, checked = 0, cycles = 0, entries, faults, n, e0;
    int pendClocks = 0, p0;
    // Rows: control write, control readback, entries expected
    logic [7:0] rowWr [7] = '{8'h3f, 8'h87, 8'h89, 8'h92, 8'ha4, 8'ha2, 8'hc0};
    logic [7:0] rowRd [7] = '{8'h3f, 8'h87, 8'h09, 8'h12, 8'h24, 8'ha2, 8'h80};
    int rowEnt [7] = '{0, 0, 1, 1, 1, 0, 0};

    iclg_interrupt_control u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .clkEn(clkEn),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .externalIntPin(extPin), .portBUpperPins(portPins),
        .timerZeroOverflow(tmrOv), .returnFromService(ret), .intPending(intPending),
        .forceNop(forceNop), .pushReturn(pushReturn), .vectorLoad(vectorLoad),
        .vectorAddr(vectorAddr), .irqOut(irqOut));
    iclg_core_model u_core (.ref_clk(ref_clk), .retReq(retReq), .vectorLoad(vectorLoad),
        .pushReturn(pushReturn), .vectorAddr(vectorAddr), .returnFromService(ret),
        .entries(entries), .faults(faults));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // Bus tasks and compares
    // ----------------------------------------
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe, so sample mid-cycle
    task automatic rd(input logic [1:0] a);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        @(negedge ref_clk);
        rdv = regRdData;
    endtask
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmpN(input int got, input int exp);
        checked++;
        if (got != exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    // Event to vector load, bounded wait
    task automatic lat(input logic [7:0] ctl);
        extPin <= 1'b0;
        wr(2'h0, 8'h00);
        wr(2'h0, ctl);
        cyc(4);
        if (ctl[4]) extPin <= 1'b1;
        else portPins <= ~portPins;
        n = 0;
        while (vectorLoad !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            n++;
        end
        // Load starts the vector cycle, so entry is 8 to 12 clocks after the pin
        cmp8({7'h0, n >= 8 && n <= 12}, 8'h01);
    endtask
    task automatic conclude;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Hang guard, well above the expected run length
    always @(posedge ref_clk) begin
        cycles++;
        if (intPending === 1'b1) begin
            pendClocks++;
        end
        if (cycles == 3000) begin
            miscompares++;
            conclude();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge ref_clk);
        rst_b <= 1'b1;
        cyc(3);
        rd(2'h0);
        cmp8(rdv, 8'h00);
        cmp8({6'h0, irqOut, intPending}, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            e0 = entries;
            p0 = pendClocks;
            wr(2'h0, rowWr[i]);
            cyc(16);
            rd(2'h0);
            cmp8(rdv, rowRd[i]);
            cmpN(entries - e0, rowEnt[i]);
            cmpN(pendClocks > p0, rowEnt[i]);
            wr(2'h0, 8'h00);
            cyc(8);
        end
        $display("test rows done");
        // Flags pend while the global enable is off; only the accepted event is unmasked onto irqOut
        cmp8({7'h0, irqOut}, 8'h00);
        wr(2'h1, 8'h07);
        wr(2'h2, 8'h01);
        wr(2'h0, 8'h10);
        tmrOv <= 1'b1;
        @(posedge ref_clk);
        tmrOv <= 1'b0;
        extPin <= 1'b1;
        portPins <= 4'h9;
        e0 = entries;
        cyc(8);
        rd(2'h0);
        cmp8(rdv, 8'h17);
        cmpN(entries - e0, 0);
        retReq <= 1'b1;
        @(posedge ref_clk);
        retReq <= 1'b0;
        cyc(16);
        cmpN(entries - e0, 1);
        cmp8({7'h0, irqOut}, 8'h01);
        wr(2'h1, 8'h01);
        cyc(3);
        cmp8({7'h0, irqOut}, 8'h00);
        $display("test pending and irq done");
        wr(2'h0, 8'h80);
        wr(2'h0, 8'h00);
        n = 0;
        while (forceNop !== 1'b1 && n < 8) begin
            @(posedge ref_clk);
            n++;
        end
        cmp8({7'h0, forceNop}, 8'h01);
        $display("test no-op done");
        lat(8'h90);
        lat(8'h88);
        cyc(8);
        wr(2'h3, 8'hff);
        rd(2'h3);
        cmp8(rdv, 8'h00);
        cmpN(faults, 0);
        $display("test latency done");
        // Mid-run reset with the global enable set and port pins away from zero
        wr(2'h0, 8'h80);
        rd(2'h0);
        cmp8(rdv, 8'h80);
        @(posedge ref_clk);
        rst_b <= 1'b0;
        cyc(4);
        rst_b <= 1'b1;
        cyc(6);
        rd(2'h0);
        cmp8(rdv, 8'h00);
        cmp8({6'h0, irqOut, intPending}, 8'h00);
        $display("test reset again done");
        conclude();
    end
endmodule
`default_nettype wire
